// ---- verilog/signal_modulator.sv ----
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`include "signal_modulator_defines.svh"

module signal_modulator (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Pins from outside the clock domain
	input wire logic modulator_input_pin,
	input wire logic carrier_pin_one,
	input wire logic carrier_pin_two,
	input wire logic ref_clk_in,
	// On-chip peripheral outputs, same clock
	input wire logic sdo_in,
	input wire logic uart1_tx,
	input wire logic uart2_tx,
	input wire logic [4:0] pwm_in,
	// Pad and peripheral controls
	output logic modulated_output_pin,
	output logic slew_limit_pad,
	output logic [7:0] periph_pin_disable
);

	signal_modulator_pkg::state_s state_ff;
	signal_modulator_pkg::state_s nxt_state;
	logic [7:0] periph_vec;
	logic high_time_carrier_fall;
	logic low_time_carrier_fall;
	logic mixed;
	logic out_val;

	////////////////////////////////////////////////////////////////////////////////

	function automatic signal_modulator_pkg::ctrl_s ctrl_from_byte(input logic [7:0] b);
		signal_modulator_pkg::ctrl_s c;
		c.en = b[`CTRL_EN_BIT];
		c.oe = b[`CTRL_OE_BIT];
		c.slew = b[`CTRL_SLEW_BIT];
		c.pol = b[`CTRL_POL_BIT];
		c.sw_bit = b[`CTRL_SW_BIT];
		return c;
	endfunction

	function automatic signal_modulator_pkg::src_s src_from_byte(input logic [7:0] b);
		signal_modulator_pkg::src_s s;
		s.pin_dis = b[`SEL_PIN_DIS_BIT];
		s.sel = b[3:0];
		return s;
	endfunction

	function automatic signal_modulator_pkg::car_s car_from_byte(input logic [7:0] b);
		signal_modulator_pkg::car_s c;
		c.pin_dis = b[`SEL_PIN_DIS_BIT];
		c.pol = b[`CAR_POL_BIT];
		c.sync = b[`CAR_SYNC_BIT];
		c.sel = b[3:0];
		return c;
	endfunction

	function automatic logic [7:0] car_to_byte(input signal_modulator_pkg::car_s c);
		return {c.pin_dis, c.pol, c.sync, 1'b0, c.sel};
	endfunction

	// Flat peripheral vector: 0 serial data, 1-2 uarts, 3-7 PWM units
	assign periph_vec = state_ff.periph_q;

	function automatic logic pick_mod(input logic [3:0] sel, input logic sw,
			input logic pin, input logic [7:0] pv);
		logic r;
		r = 1'b0;
		case (sel)
			`SRC_SW_BIT: r = sw;
			`SRC_PIN: r = pin;
			`SRC_SDO: r = pv[0];
			`SRC_TX1: r = pv[1];
			`SRC_TX2: r = pv[2];
			4'h5: r = pv[3];
			4'h6: r = pv[4];
			4'h7: r = pv[5];
			4'h8: r = pv[6];
			4'h9: r = pv[7];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic pick_car(input logic [3:0] sel,
			input signal_modulator_pkg::pins_s ps, input logic [7:0] pv);
		logic r;
		r = 1'b0;
		case (sel)
			`CAR_GROUND: r = 1'b0;
			`CAR_PIN_ONE: r = ps.cin1;
			`CAR_PIN_TWO: r = ps.cin2;
			`CAR_REF_CLK: r = ps.ref_clk;
			4'h4: r = pv[3];
			4'h5: r = pv[4];
			4'h6: r = pv[5];
			4'h7: r = pv[6];
			4'h8: r = pv[7];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	assign high_time_carrier_fall = state_ff.high_time_carrier_prev & ~state_ff.high_time_carrier_q;
	assign low_time_carrier_fall = state_ff.low_time_carrier_prev & ~state_ff.low_time_carrier_q;

	always_comb begin
		nxt_state = state_ff;

		// Two flip-flops for every pin; only the second is read by logic
		nxt_state.pin_meta.mod_in = modulator_input_pin;
		nxt_state.pin_meta.cin1 = carrier_pin_one;
		nxt_state.pin_meta.cin2 = carrier_pin_two;
		nxt_state.pin_meta.ref_clk = ref_clk_in;
		nxt_state.pin_sync = state_ff.pin_meta;
		nxt_state.periph_q = {pwm_in, uart2_tx, uart1_tx, sdo_in};

		// Selection and carrier polarity; disabled forces ground and software bit
		if (state_ff.ctrl.en) begin
			nxt_state.mod_q = pick_mod(state_ff.src.sel, state_ff.ctrl.sw_bit,
				state_ff.pin_sync.mod_in, periph_vec);
			nxt_state.high_time_carrier_q = state_ff.high_time_carrier.pol ^
				pick_car(state_ff.high_time_carrier.sel, state_ff.pin_sync, periph_vec);
			nxt_state.low_time_carrier_q = state_ff.low_time_carrier.pol ^
				pick_car(state_ff.low_time_carrier.sel, state_ff.pin_sync, periph_vec);
		end else begin
			nxt_state.mod_q = state_ff.ctrl.sw_bit;
			nxt_state.high_time_carrier_q = 1'b0;
			nxt_state.low_time_carrier_q = 1'b0;
		end
		nxt_state.high_time_carrier_prev = state_ff.high_time_carrier_q;
		nxt_state.low_time_carrier_prev = state_ff.low_time_carrier_q;

		// Carrier switching; sync holds the old carrier until its pulse ends
		case (state_ff.phase)
			signal_modulator_pkg::PH_HIGH: begin
				if (!state_ff.mod_q && (!state_ff.high_time_carrier.sync || high_time_carrier_fall)) begin
					nxt_state.phase = signal_modulator_pkg::PH_LOW;
				end
			end
			signal_modulator_pkg::PH_LOW: begin
				if (state_ff.mod_q && (!state_ff.low_time_carrier.sync || low_time_carrier_fall)) begin
					nxt_state.phase = signal_modulator_pkg::PH_HIGH;
				end
			end
			default: begin
				nxt_state.phase = signal_modulator_pkg::PH_LOW;
			end
		endcase

		// Mix, invert, gate to the pin
		mixed = (nxt_state.phase == signal_modulator_pkg::PH_HIGH) ?
			state_ff.high_time_carrier_q : state_ff.low_time_carrier_q;
		out_val = state_ff.ctrl.pol ^ mixed;
		nxt_state.status = out_val;
		nxt_state.out = state_ff.ctrl.en & state_ff.ctrl.oe & out_val;

		// Pin disables follow the stored selections even while disabled
		for (int i = 0; i < 8; i++) begin
			nxt_state.pin_dis[i] =
				(state_ff.src.pin_dis && state_ff.src.sel == 4'(i + 2)) ||
				(i >= 3 && state_ff.high_time_carrier.pin_dis && state_ff.high_time_carrier.sel == 4'(i + 1)) ||
				(i >= 3 && state_ff.low_time_carrier.pin_dis && state_ff.low_time_carrier.sel == 4'(i + 1));
		end

		// Register writes; the status bit ignores writes
		if (reg_wr) begin
			case (reg_addr)
				`ADDR_CONTROL: nxt_state.ctrl = ctrl_from_byte(reg_wdata);
				`ADDR_SOURCE: nxt_state.src = src_from_byte(reg_wdata);
				`ADDR_HIGH_CARRIER: nxt_state.high_time_carrier = car_from_byte(reg_wdata);
				`ADDR_LOW_CARRIER: nxt_state.low_time_carrier = car_from_byte(reg_wdata);
				default: nxt_state.ctrl = state_ff.ctrl;
			endcase
		end

		// Read data stands only in the cycle after the strobe
		nxt_state.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`ADDR_CONTROL: nxt_state.rdata = {state_ff.ctrl.en, state_ff.ctrl.oe,
					state_ff.ctrl.slew, state_ff.ctrl.pol, state_ff.status, 2'b00,
					state_ff.ctrl.sw_bit};
				`ADDR_SOURCE: nxt_state.rdata = {state_ff.src.pin_dis, 3'b000,
					state_ff.src.sel};
				`ADDR_HIGH_CARRIER: nxt_state.rdata = car_to_byte(state_ff.high_time_carrier);
				`ADDR_LOW_CARRIER: nxt_state.rdata = car_to_byte(state_ff.low_time_carrier);
				default: nxt_state.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_ff <= '0;
			state_ff.ctrl <= ctrl_from_byte(`RST_CONTROL);
			state_ff.src <= src_from_byte(`RST_SOURCE);
			state_ff.high_time_carrier <= car_from_byte(`RST_HIGH_CARRIER);
			state_ff.low_time_carrier <= car_from_byte(`RST_LOW_CARRIER);
			state_ff.phase <= signal_modulator_pkg::PH_LOW;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign reg_rdata = state_ff.rdata;
	assign modulated_output_pin = state_ff.out;
	assign slew_limit_pad = state_ff.ctrl.slew;
	assign periph_pin_disable = state_ff.pin_dis;

	////////////////////////////////////////////////////////////////////////////////

	property p_oe_holds_low;
		@(posedge core_clk) disable iff (!rst_n)
		!state_ff.ctrl.oe |=> !modulated_output_pin;
	endproperty
	a_oe_holds_low: assert property (p_oe_holds_low)
		else $error("output pin not low while output disabled");

	property p_disabled_no_output;
		@(posedge core_clk) disable iff (!rst_n)
		!state_ff.ctrl.en |=> !modulated_output_pin;
	endproperty
	a_disabled_no_output: assert property (p_disabled_no_output)
		else $error("output active while module disabled");

	property p_slew_write;
		@(posedge core_clk) disable iff (!rst_n)
		reg_wr && reg_addr == `ADDR_CONTROL |=>
			slew_limit_pad == $past(reg_wdata[`CTRL_SLEW_BIT]);
	endproperty
	a_slew_write: assert property (p_slew_write)
		else $error("slew limit does not follow control write");

	property p_out_polarity;
		@(posedge core_clk) disable iff (!rst_n)
		state_ff.ctrl.en && state_ff.ctrl.oe |=>
			modulated_output_pin == ($past(state_ff.ctrl.pol) ^ $past(mixed));
	endproperty
	a_out_polarity: assert property (p_out_polarity)
		else $error("output polarity wrong");

	property p_status_read;
		@(posedge core_clk) disable iff (!rst_n)
		reg_rd && reg_addr == `ADDR_CONTROL |=>
			reg_rdata[`CTRL_STATUS_BIT] == $past(state_ff.status) && reg_rdata[2:1] == 2'b00;
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("control read shows wrong status or reserved bits");

	property p_source_reserved;
		@(posedge core_clk) disable iff (!rst_n)
		reg_rd && reg_addr == `ADDR_SOURCE |=> reg_rdata[6:4] == 3'b000;
	endproperty
	a_source_reserved: assert property (p_source_reserved)
		else $error("source register reserved bits read nonzero");

	property p_carrier_reserved;
		@(posedge core_clk) disable iff (!rst_n)
		reg_rd && (reg_addr == `ADDR_HIGH_CARRIER || reg_addr == `ADDR_LOW_CARRIER) |=>
			reg_rdata[4] == 1'b0;
	endproperty
	a_carrier_reserved: assert property (p_carrier_reserved)
		else $error("carrier register reserved bit reads nonzero");

	property p_rdata_idle;
		@(posedge core_clk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data present without a read");

	property p_disabled_sources;
		@(posedge core_clk) disable iff (!rst_n)
		!state_ff.ctrl.en |=> !state_ff.high_time_carrier_q && !state_ff.low_time_carrier_q &&
			state_ff.mod_q == $past(state_ff.ctrl.sw_bit);
	endproperty
	a_disabled_sources: assert property (p_disabled_sources)
		else $error("disabled module not forced to ground and software bit");

	property p_sw_bit_source;
		@(posedge core_clk) disable iff (!rst_n)
		state_ff.ctrl.en && state_ff.src.sel == `SRC_SW_BIT |=>
			state_ff.mod_q == $past(state_ff.ctrl.sw_bit);
	endproperty
	a_sw_bit_source: assert property (p_sw_bit_source)
		else $error("software bit not used as modulator");

	property p_reserved_source;
		@(posedge core_clk) disable iff (!rst_n)
		state_ff.ctrl.en && state_ff.src.sel > 4'h9 |=> !state_ff.mod_q;
	endproperty
	a_reserved_source: assert property (p_reserved_source)
		else $error("reserved source code drives the modulator");

	property p_high_fixed_carrier;
		@(posedge core_clk) disable iff (!rst_n)
		state_ff.ctrl.en && (state_ff.high_time_carrier.sel == `CAR_GROUND || state_ff.high_time_carrier.sel > 4'h8) |=>
			state_ff.high_time_carrier_q == $past(state_ff.high_time_carrier.pol);
	endproperty
	a_high_fixed_carrier: assert property (p_high_fixed_carrier)
		else $error("grounded or reserved high carrier not at its polarity level");

	property p_low_fixed_carrier;
		@(posedge core_clk) disable iff (!rst_n)
		state_ff.ctrl.en && (state_ff.low_time_carrier.sel == `CAR_GROUND || state_ff.low_time_carrier.sel > 4'h8) |=>
			state_ff.low_time_carrier_q == $past(state_ff.low_time_carrier.pol);
	endproperty
	a_low_fixed_carrier: assert property (p_low_fixed_carrier)
		else $error("grounded or reserved low carrier not at its polarity level");

	property p_high_sync_hold;
		@(posedge core_clk) disable iff (!rst_n)
		state_ff.phase == signal_modulator_pkg::PH_HIGH && state_ff.high_time_carrier.sync && !high_time_carrier_fall
			|=> state_ff.phase == signal_modulator_pkg::PH_HIGH;
	endproperty
	a_high_sync_hold: assert property (p_high_sync_hold)
		else $error("left high carrier without falling edge");

	property p_low_sync_hold;
		@(posedge core_clk) disable iff (!rst_n)
		state_ff.phase == signal_modulator_pkg::PH_LOW && state_ff.low_time_carrier.sync && !low_time_carrier_fall
			|=> state_ff.phase == signal_modulator_pkg::PH_LOW;
	endproperty
	a_low_sync_hold: assert property (p_low_sync_hold)
		else $error("left low carrier without falling edge");

	property p_no_sync_follow;
		@(posedge core_clk) disable iff (!rst_n)
		!state_ff.high_time_carrier.sync && !state_ff.low_time_carrier.sync |=>
			(state_ff.phase == signal_modulator_pkg::PH_HIGH) == $past(state_ff.mod_q);
	endproperty
	a_no_sync_follow: assert property (p_no_sync_follow)
		else $error("carrier switch not immediate without sync");

	property p_source_pin_disable;
		@(posedge core_clk) disable iff (!rst_n)
		state_ff.src.pin_dis && state_ff.src.sel == `SRC_SDO |=> periph_pin_disable[0];
	endproperty
	a_source_pin_disable: assert property (p_source_pin_disable)
		else $error("source peripheral pin not disabled");

	property p_high_pin_disable;
		@(posedge core_clk) disable iff (!rst_n)
		state_ff.high_time_carrier.pin_dis && state_ff.high_time_carrier.sel == 4'h5 |=> periph_pin_disable[4];
	endproperty
	a_high_pin_disable: assert property (p_high_pin_disable)
		else $error("high carrier peripheral pin not disabled");

	property p_low_pin_disable;
		@(posedge core_clk) disable iff (!rst_n)
		state_ff.low_time_carrier.pin_dis && state_ff.low_time_carrier.sel == 4'h8 |=> periph_pin_disable[7];
	endproperty
	a_low_pin_disable: assert property (p_low_pin_disable)
		else $error("low carrier peripheral pin not disabled");

	// No disable here: this one watches the reset itself
	property p_reset_defaults;
		@(posedge core_clk)
		!rst_n |=> !state_ff.ctrl.en && slew_limit_pad && !modulated_output_pin &&
			reg_rdata == 8'h00 && periph_pin_disable == 8'h00;
	endproperty
	a_reset_defaults: assert property (p_reset_defaults)
		else $error("reset did not restore defaults");

	property p_out_gate;
		@(posedge core_clk) disable iff (!rst_n)
		state_ff.ctrl.en && state_ff.ctrl.oe |=> modulated_output_pin == state_ff.status;
	endproperty
	a_out_gate: assert property (p_out_gate)
		else $error("enabled output pin differs from status");

endmodule // signal_modulator

// ---- verilog/signal_modulator_defines.svh ----
`ifndef SIGNAL_MODULATOR_DEFINES_SVH
`define SIGNAL_MODULATOR_DEFINES_SVH

// Register indices on the 2-bit register port
`define ADDR_CONTROL 2'h0
`define ADDR_SOURCE 2'h1
`define ADDR_HIGH_CARRIER 2'h2
`define ADDR_LOW_CARRIER 2'h3

// Reset values
`define RST_CONTROL 8'h20
`define RST_SOURCE 8'h00
`define RST_HIGH_CARRIER 8'h00
`define RST_LOW_CARRIER 8'h00

// Field positions
`define CTRL_EN_BIT 7
`define CTRL_OE_BIT 6
`define CTRL_SLEW_BIT 5
`define CTRL_POL_BIT 4
`define CTRL_STATUS_BIT 3
`define CTRL_SW_BIT 0
`define SEL_PIN_DIS_BIT 7
`define CAR_POL_BIT 6
`define CAR_SYNC_BIT 5

// Selection codes
`define SRC_SW_BIT 4'h0
`define SRC_PIN 4'h1
`define SRC_SDO 4'h2
`define SRC_TX1 4'h3
`define SRC_TX2 4'h4
`define SRC_PWM_FIRST 4'h5
`define CAR_GROUND 4'h0
`define CAR_PIN_ONE 4'h1
`define CAR_PIN_TWO 4'h2
`define CAR_REF_CLK 4'h3
`define CAR_PWM_FIRST 4'h4

`endif

// ---- verilog/signal_modulator_pkg.sv ----
package signal_modulator_pkg;

	typedef struct packed {
		logic en;
		logic oe;
		logic slew;
		logic pol;
		logic sw_bit;
	} ctrl_s;

	typedef struct packed {
		logic pin_dis;
		logic [3:0] sel;
	} src_s;

	typedef struct packed {
		logic pin_dis;
		logic pol;
		logic sync;
		logic [3:0] sel;
	} car_s;

	// Pin-side inputs that need synchronising
	typedef struct packed {
		logic mod_in;
		logic cin1;
		logic cin2;
		logic ref_clk;
	} pins_s;

	typedef enum logic [1:0] {
		PH_LOW = 2'b01,
		PH_HIGH = 2'b10
	} phase_e;

	typedef struct packed {
		ctrl_s ctrl;
		src_s src;
		car_s high_time_carrier;
		car_s low_time_carrier;
		pins_s pin_meta;
		pins_s pin_sync;
		logic [7:0] periph_q;
		logic mod_q;
		logic high_time_carrier_q;
		logic low_time_carrier_q;
		logic high_time_carrier_prev;
		logic low_time_carrier_prev;
		phase_e phase;
		logic status;
		logic out;
		logic [7:0] pin_dis;
		logic [7:0] rdata;
	} state_s;

endpackage

// ---- testbench/periph_model.sv ----
`timescale 1ns/100ps

module periph_model (
	// Levels commanded by the bench, and pin disables from the modulator
	input wire logic [11:0] lvl,
	input wire logic [7:0] pin_dis,
	// Peripheral outputs and pins seen by the modulator
	output logic sdo_in,
	output logic uart1_tx,
	output logic uart2_tx,
	output logic [4:0] pwm_in,
	output logic modulator_input_pin,
	output logic carrier_pin_one,
	output logic carrier_pin_two,
	output logic ref_clk_in,
	// Pads of the peripherals themselves
	output logic [7:0] per_pin
);
	assign {ref_clk_in, carrier_pin_two, carrier_pin_one, modulator_input_pin} = lvl[11:8];
	assign {pwm_in, uart2_tx, uart1_tx, sdo_in} = lvl[7:0];
	// A released pad falls to its pull-down rather than keeping the last level
	assign per_pin = lvl[7:0] & ~pin_dis;
endmodule // periph_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps

module tb_top;
	logic core_clk, rst_n, reg_wr, reg_rd;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, periph_pin_disable, per_pin;
	logic [11:0] lvl;
	logic sdo_in, uart1_tx, uart2_tx, modulator_input_pin, carrier_pin_one;
	logic carrier_pin_two, ref_clk_in, modulated_output_pin, slew_limit_pad;
	logic [4:0] pwm_in;
	int n_mismatch, n_checks;

	signal_modulator i_signal_modulator (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .modulator_input_pin, .carrier_pin_one, .carrier_pin_two,
		.ref_clk_in, .sdo_in, .uart1_tx, .uart2_tx, .pwm_in, .modulated_output_pin,
		.slew_limit_pad, .periph_pin_disable);
	periph_model i_periph_model (.lvl, .pin_dis(periph_pin_disable), .sdo_in, .uart1_tx,
		.uart2_tx, .pwm_in, .modulator_input_pin, .carrier_pin_one, .carrier_pin_two,
		.ref_clk_in, .per_pin);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// Every driver task starts just after an edge and ends 1 ns after one
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic chk_out(input logic e);
		chk({7'h00, modulated_output_pin}, {7'h00, e});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] d;
		rst_n <= 1'b0;
		cyc(2);
		rst_n <= 1'b1;
		#1;
		chk({7'h00, slew_limit_pad}, 8'h01);
		chk(periph_pin_disable, 8'h00);
		chk_out(1'b0);
		rd(2'h0, d);
		chk(d, 8'h20);
		for (int a = 1; a < 4; a++) begin
			rd(a[1:0], d);
			chk(d, 8'h00);
		end
	endtask

	task automatic t_regs();
		logic [7:0] d;
		wr(2'h0, 8'h2F);
		rd(2'h0, d);
		chk(d, 8'h21);
		wr(2'h1, 8'hFF);
		rd(2'h1, d);
		chk(d, 8'h8F);
		wr(2'h2, 8'hFF);
		wr(2'h3, 8'hFF);
		rd(2'h2, d);
		chk(d, 8'hEF);
		rd(2'h3, d);
		chk(d, 8'hEF);
	endtask

	function automatic logic [11:0] src_hot(input logic [3:0] c);
		if (c == 4'h1) return 12'h100;
		if (c >= 4'h2 && c <= 4'h9) return 12'h001 << (c - 4'h2);
		return 12'h000;
	endfunction

	function automatic logic [11:0] car_hot(input logic [3:0] c);
		if (c >= 4'h1 && c <= 4'h3) return 12'h001 << (c + 4'h8);
		if (c >= 4'h4 && c <= 4'h8) return 12'h001 << (c - 4'h1);
		return 12'h000;
	endfunction

	// Inverted ground as high carrier, ground as low: output shows the modulator
	task automatic t_source();
		logic [3:0] c;
		logic v;
		wr(2'h2, 8'h40);
		wr(2'h3, 8'h00);
		for (int i = 0; i < 32; i++) begin
			c = i[4:1];
			v = i[0];
			wr(2'h1, {4'h0, c});
			wr(2'h0, {7'h70, (c == 4'h0) ? v : ~v});
			lvl <= (c == 4'h0) ? {12{~v}} : (c > 4'h9) ? {12{v}} : v ? src_hot(c) : ~src_hot(c);
			cyc(8);
			chk_out((c <= 4'h9) ? v : 1'b0);
		end
	endtask

	task automatic t_carrier();
		logic [3:0] c;
		logic p, v, s;
		wr(2'h1, 8'h00);
		for (int i = 0; i < 128; i++) begin
			s = i[0];
			v = i[1];
			p = i[2];
			c = 4'(i / 8);
			wr(2'h2, s ? 8'h00 : {1'b0, p, 2'b00, c});
			wr(2'h3, s ? {1'b0, p, 2'b00, c} : 8'h00);
			wr(2'h0, {7'h70, ~s});
			lvl <= v ? car_hot(c) : ~car_hot(c);
			cyc(8);
			chk_out((c == 4'h0 || c > 4'h8) ? p : v ^ p);
		end
	endtask

	task automatic t_gate();
		logic [7:0] d;
		lvl <= 12'h000;
		wr(2'h1, 8'h00);
		wr(2'h2, 8'h40);
		wr(2'h3, 8'h00);
		wr(2'h0, 8'hA1);
		cyc(6);
		chk_out(1'b0);
		rd(2'h0, d);
		chk(d, 8'hA9);
		wr(2'h0, 8'hE1);
		cyc(6);
		chk_out(1'b1);
		wr(2'h0, 8'hF1);
		cyc(6);
		chk_out(1'b0);
		rd(2'h0, d);
		chk(d, 8'hF1);
		wr(2'h0, 8'h71);
		cyc(6);
		chk_out(1'b0);
		rd(2'h0, d);
		chk(d, 8'h79);
		rd(2'h2, d);
		chk(d, 8'h40);
		wr(2'h0, 8'hE1);
		cyc(6);
		chk_out(1'b1);
		wr(2'h0, 8'hC1);
		cyc(3);
		chk({7'h00, slew_limit_pad}, 8'h00);
	endtask

	task automatic t_sync();
		wr(2'h3, 8'h00);
		wr(2'h2, 8'h24);
		lvl <= 12'h008;
		wr(2'h0, 8'hE1);
		cyc(6);
		chk_out(1'b1);
		wr(2'h0, 8'hE0);
		cyc(8);
		chk_out(1'b1);
		lvl <= 12'h000;
		cyc(6);
		chk_out(1'b0);
		lvl <= 12'h008;
		cyc(6);
		chk_out(1'b0);
		wr(2'h2, 8'h00);
		wr(2'h3, 8'h25);
		lvl <= 12'h010;
		cyc(6);
		chk_out(1'b1);
		wr(2'h0, 8'hE1);
		cyc(8);
		chk_out(1'b1);
		lvl <= 12'h000;
		cyc(6);
		chk_out(1'b0);
		wr(2'h3, 8'h05);
		lvl <= 12'h010;
		wr(2'h0, 8'hE0);
		cyc(6);
		chk_out(1'b1);
		wr(2'h0, 8'hE1);
		cyc(6);
		chk_out(1'b0);
	endtask

	task automatic t_pin_dis();
		lvl <= 12'h0FF;
		wr(2'h1, 8'h82);
		wr(2'h2, 8'h85);
		wr(2'h3, 8'h88);
		cyc(3);
		chk(periph_pin_disable, 8'h91);
		chk(per_pin, 8'h6E);
		wr(2'h2, 8'h05);
		wr(2'h1, 8'h89);
		cyc(3);
		chk(periph_pin_disable, 8'h80);
		chk(per_pin, 8'h7F);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		lvl = 12'h000;
		t_reset();
		t_regs();
		t_source();
		t_carrier();
		t_gate();
		t_sync();
		t_pin_dis();
		t_reset();
		finish_test();
	end

	// Whole run is near 1900 cycles; the margin only guards a hang
	initial begin
		repeat (8000) @(posedge core_clk);
		n_mismatch++;
		finish_test();
	end
endmodule // tb_top
